//--- tap_pkg.sv
// shared constants and types for the boundary-scan test access port
package tap_pkg;

  // ----------------------------------------------------------------
  // chain geometry
  // ----------------------------------------------------------------
  localparam int IO_CELLS  = 32;
  localparam int IN_CELLS  = 4;
  localparam int MC_CELLS  = 32;
  localparam int IO_STAGES = 3;
  localparam int IN_BASE   = IO_CELLS * IO_STAGES;
  localparam int MC_BASE   = IN_BASE + IN_CELLS;
  localparam int CHAIN_LEN = MC_BASE + MC_CELLS;
  localparam int IR_W      = 4;
  localparam int WORD_W    = 32;
  localparam int SIG_W     = 16;
  localparam int AUX_W     = 4;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
  localparam logic [IR_W-1:0] IR_IDCODE  = 4'h2;
  localparam logic [IR_W-1:0] IR_HIGHZ   = 4'h3;
  localparam logic [IR_W-1:0] IR_PROG    = 4'h8;
  localparam logic [IR_W-1:0] IR_VERIFY  = 4'h9;
  localparam logic [IR_W-1:0] IR_SIG     = 4'hA;
  localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET   = IR_IDCODE;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic [IO_CELLS-1:0] io;
    logic [IN_CELLS-1:0] in;
  } pin_in_t;

  typedef struct packed {
    logic [IO_CELLS-1:0] out;
    logic [IO_CELLS-1:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic extest;
    logic highz;
    logic lock;
  } tap_mode_t;

  // everything the link side samples from the core side
  typedef struct packed {
    pin_in_t             pin;
    pin_drive_t          drv;
    logic [MC_CELLS-1:0] mc;
    logic [WORD_W-1:0]   rb;
    logic [SIG_W-1:0]    sig;
    logic                fuse;
    logic                en;
    logic                ack;
  } obs_t;

endpackage : tap_pkg

//--- boundary_scan_tap.sv
// boundary-scan test access port with chain, programming path and pin control
`timescale 1ns/100ps
// Function
// RQ1: no test reset pin; power-up reset forces the controller to its reset state.
// RQ2: decode sample/preload, extest, bypass, idcode and highz with standard behaviour.
// RQ3: each input pin and each I/O pin owns a scan cell.
// RQ4: chain sized for 32 I/O pins and 4 dedicated inputs.
// RQ5: two cell kinds exist: pin cells and macrocell cells.
// RQ6: pin cell has three capture stages and two update stages.
// RQ7: cells chained through capture stages, from tdi in to tdo out.
// RQ8: capture stages sample signals, shift data, and load update stages.
// RQ9: capture, shift and update controls come from the internal controller.
// RQ10: port can be disabled, giving its four pins back as general I/O.
// RQ11: configuration is programmed only over the four port pins.
// RQ12: optional pull-ups on tms and tdi selected by configuration.
// RQ13: secured device reads back zeros on verify; signature stays readable.
// RQ14: interrupted programming locks the device and floats all pins; the code floats only the 32 I/O pins (io_oe), not tdo or the aux pins.
// RQ15: bypass uses a one-stage register; highz also bypasses and floats outputs.
// RQ16: idcode selects a 32-bit register with lsb one, captured then shifted.
module boundary_scan_tap
  import tap_pkg::*;
#(
  parameter logic [WORD_W-1:0] IDCODE_VALUE = 32'h0A5C_3001  // arbitrary value
) (
  // core clock and power-up reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // test link
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo_o,
  output logic                     tdo_oe,
  // configuration straps
  input  wire logic                jtag_en,
  input  wire logic                cfg_tms_pullup,
  input  wire logic                cfg_tdi_pullup,
  output logic                     tms_pullup_en,
  output logic                     tdi_pullup_en,
  // port pins reused as general I/O
  input  wire logic [AUX_W-1:0]    aux_i,
  input  wire logic [AUX_W-1:0]    core_aux_o,
  input  wire logic [AUX_W-1:0]    core_aux_oe,
  output logic      [AUX_W-1:0]    aux_o,
  output logic      [AUX_W-1:0]    aux_oe,
  output logic      [AUX_W-1:0]    aux_in,
  // device pins and core logic
  input  wire pin_in_t             pin_i,
  input  wire pin_drive_t          core_drive,
  input  wire logic [MC_CELLS-1:0] mc_state,
  output logic      [IO_CELLS-1:0] io_o,
  output logic      [IO_CELLS-1:0] io_oe,
  // configuration store
  input  wire logic [WORD_W-1:0]   cfg_readback,
  input  wire logic [SIG_W-1:0]    user_signature,
  input  wire logic                secure_fuse,
  input  wire logic                prog_ready,
  output logic      [WORD_W-1:0]   prog_data,
  output logic                     prog_valid,
  output logic                     dev_locked
);

  // ----------------------------------------------------------------
  // link domain: input sampling
  // ----------------------------------------------------------------
  obs_t obs_raw;
  obs_t obs_s1_reg;
  obs_t obs_reg;
  logic jtag_en_reg;
  logic req_seen_reg;

  assign obs_raw = {pin_i, core_drive, mc_state, cfg_readback, user_signature,
                    secure_fuse, jtag_en_reg, req_seen_reg};

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      obs_s1_reg <= '0;
      obs_reg    <= '0;
    end else begin
      obs_s1_reg <= obs_raw;
      obs_reg    <= obs_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------
  tap_state_t state_reg;
  tap_state_t state_next;
  tap_state_t state_step;

  always_comb begin
    case (state_reg)
      S_TLR:    state_step = tms ? S_TLR    : S_RTI;
      S_RTI:    state_step = tms ? S_SEL_DR : S_RTI;
      S_SEL_DR: state_step = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: state_step = tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR:  state_step = tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: state_step = tms ? S_UPD_DR : S_PA_DR;
      S_PA_DR:  state_step = tms ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: state_step = tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: state_step = tms ? S_SEL_DR : S_RTI;
      S_SEL_IR: state_step = tms ? S_TLR    : S_CAP_IR;
      S_CAP_IR: state_step = tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR:  state_step = tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: state_step = tms ? S_UPD_IR : S_PA_IR;
      S_PA_IR:  state_step = tms ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: state_step = tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: state_step = tms ? S_SEL_DR : S_RTI;
      default:  state_step = S_TLR;
    endcase
  end

  // a disabled port is held in its reset state
  assign state_next = obs_reg.en ? state_step : S_TLR;  // see RQ10

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) state_reg <= S_TLR;  // see RQ1
    else        state_reg <= state_next;
  end

  wire in_tlr = (state_reg == S_TLR);
  wire cap_dr = (state_reg == S_CAP_DR);  // see RQ9
  wire sh_dr  = (state_reg == S_SH_DR);
  wire upd_dr = (state_reg == S_UPD_DR);
  wire cap_ir = (state_reg == S_CAP_IR);
  wire sh_ir  = (state_reg == S_SH_IR);
  wire upd_ir = (state_reg == S_UPD_IR);

  // ----------------------------------------------------------------
  // instruction register and decode
  // ----------------------------------------------------------------
  logic [IR_W-1:0] ir_sr_reg;
  logic [IR_W-1:0] ir_reg;

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      ir_sr_reg <= IR_CAPTURE;
      ir_reg    <= IR_RESET;
    end else begin
      if (cap_ir)     ir_sr_reg <= IR_CAPTURE;
      else if (sh_ir) ir_sr_reg <= {tdi, ir_sr_reg[IR_W-1:1]};
      if (in_tlr)      ir_reg <= IR_RESET;
      else if (upd_ir) ir_reg <= ir_sr_reg;
    end
  end

  wire is_extest = (ir_reg == IR_EXTEST);  // see RQ2
  wire is_sample = (ir_reg == IR_SAMPLE);
  wire is_idcode = (ir_reg == IR_IDCODE);
  wire is_highz  = (ir_reg == IR_HIGHZ);
  wire is_prog   = (ir_reg == IR_PROG);
  wire is_verify = (ir_reg == IR_VERIFY);
  wire is_sig    = (ir_reg == IR_SIG);
  wire sel_bsr   = is_extest | is_sample;
  wire sel_word  = is_idcode | is_prog | is_verify | is_sig;

  // ----------------------------------------------------------------
  // boundary chain
  // ----------------------------------------------------------------
  logic [CHAIN_LEN-1:0] cap_vec;
  logic [CHAIN_LEN-1:0] bsr_reg;
  logic [IO_CELLS-1:0]  upd_src_out;
  logic [IO_CELLS-1:0]  upd_src_oe;
  pin_drive_t           upd_reg;

  genvar g;
  generate
    for (g = 0; g < IO_CELLS; g++) begin : g_io_cell
      // pin cell: capture pin, output and enable; update output and enable
      assign cap_vec[IO_STAGES*g]     = obs_reg.pin.io[g];   // see RQ3
      assign cap_vec[IO_STAGES*g + 1] = obs_reg.drv.out[g];  // see RQ6
      assign cap_vec[IO_STAGES*g + 2] = obs_reg.drv.oe[g];
      assign upd_src_out[g]           = bsr_reg[IO_STAGES*g + 1];
      assign upd_src_oe[g]            = bsr_reg[IO_STAGES*g + 2];
    end
    for (g = 0; g < IN_CELLS; g++) begin : g_in_cell
      assign cap_vec[IN_BASE + g] = obs_reg.pin.in[g];  // see RQ3, RQ4
    end
    for (g = 0; g < MC_CELLS; g++) begin : g_mc_cell
      assign cap_vec[MC_BASE + g] = obs_reg.mc[g];  // see RQ5
    end
  endgenerate

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n)                 bsr_reg <= '0;
    else if (cap_dr && sel_bsr) bsr_reg <= cap_vec;                       // see RQ8
    else if (sh_dr && sel_bsr)  bsr_reg <= {tdi, bsr_reg[CHAIN_LEN-1:1]};  // see RQ7
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n)                 upd_reg <= '0;
    else if (upd_dr && sel_bsr) upd_reg <= {upd_src_out, upd_src_oe};  // see RQ8
  end

  // ----------------------------------------------------------------
  // word register, bypass and programming handshake
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] word_sr_reg;
  logic [WORD_W-1:0] word_cap;
  logic [WORD_W-1:0] prog_word_reg;
  logic              byp_reg;
  logic              prog_req_reg;
  logic              session_reg;
  logic              lock_reg;
  tap_mode_t         mode_reg;

  wire prog_busy = (prog_req_reg != obs_reg.ack);

  assign word_cap = is_idcode ? IDCODE_VALUE :                              // see RQ16
                    is_verify ? (obs_reg.fuse ? '0 : obs_reg.rb) :           // see RQ13
                    is_sig    ? {{(WORD_W-SIG_W){1'b0}}, obs_reg.sig} :
                                {{(WORD_W-1){1'b0}}, prog_busy};

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n)                  word_sr_reg <= '0;
    else if (cap_dr && sel_word) word_sr_reg <= word_cap;
    else if (sh_dr && sel_word)  word_sr_reg <= {tdi, word_sr_reg[WORD_W-1:1]};
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n)      byp_reg <= 1'b0;
    else if (cap_dr) byp_reg <= 1'b0;  // see RQ15
    else if (sh_dr)  byp_reg <= tdi;
  end

  // a word arriving while the previous one is still pending is dropped
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      prog_word_reg <= '0;
      prog_req_reg  <= 1'b0;
    end else if (upd_dr && is_prog && !prog_busy) begin
      prog_word_reg <= word_sr_reg;  // see RQ11
      prog_req_reg  <= ~prog_req_reg;
    end
  end

  // leaving the programming instruction cleanly ends a session
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      session_reg <= 1'b0;
      lock_reg    <= 1'b0;
    end else if (in_tlr && session_reg) begin
      session_reg <= 1'b0;
      lock_reg    <= 1'b1;  // see RQ14
    end else if (upd_ir && session_reg && ir_sr_reg != IR_PROG) begin
      session_reg <= 1'b0;
      lock_reg    <= 1'b0;
    end else if (upd_dr && is_prog) begin
      session_reg <= 1'b1;
    end
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) mode_reg <= '0;
    else        mode_reg <= '{extest: is_extest, highz: is_highz, lock: lock_reg};
  end

  // tdo changes on the falling edge and floats outside shift states
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo_o  <= sh_ir    ? ir_sr_reg[0] :
                sel_bsr  ? bsr_reg[0] :
                sel_word ? word_sr_reg[0] : byp_reg;  // see RQ7, RQ15
      tdo_oe <= sh_ir | sh_dr;
    end
  end

  // ----------------------------------------------------------------
  // core domain: crossings, pin control and programming buffer
  // ----------------------------------------------------------------
  tap_mode_t         mode_s1_reg;
  tap_mode_t         mode_s2_reg;
  pin_drive_t        upd_s1_reg;
  pin_drive_t        upd_s2_reg;
  logic              req_s1_reg;
  logic              req_s2_reg;
  logic [AUX_W-1:0]  aux_s1_reg;
  logic              jtag_en_s1_reg;
  logic [1:0]        pull_s1_reg;
  logic [1:0]        pull_reg;
  logic              tail_v_reg;
  logic [WORD_W-1:0] tail_d_reg;
  logic              head_v_next;
  logic [WORD_W-1:0] head_d_next;
  logic              tail_v_next;
  logic [WORD_W-1:0] tail_d_next;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_reg <= '0;
      mode_s2_reg <= '0;
      upd_s1_reg  <= '0;
      upd_s2_reg  <= '0;
      req_s1_reg  <= 1'b0;
      req_s2_reg  <= 1'b0;
      aux_s1_reg  <= '0;
      aux_in      <= '0;
      jtag_en_s1_reg <= 1'b0;
      jtag_en_reg <= 1'b0;
      pull_s1_reg <= '0;
      pull_reg    <= '0;
    end else begin
      mode_s1_reg <= mode_reg;
      mode_s2_reg <= mode_s1_reg;
      upd_s1_reg  <= upd_reg;
      upd_s2_reg  <= upd_s1_reg;
      req_s1_reg  <= prog_req_reg;
      req_s2_reg  <= req_s1_reg;
      aux_s1_reg  <= aux_i;
      aux_in      <= aux_s1_reg;
      // straps come from outside this clock: two flops before any use
      jtag_en_s1_reg <= jtag_en;
      jtag_en_reg <= jtag_en_s1_reg;  // see RQ10
      pull_s1_reg <= {cfg_tms_pullup, cfg_tdi_pullup};
      pull_reg    <= pull_s1_reg;
    end
  end

  wire pins_float = mode_s2_reg.highz | mode_s2_reg.lock;  // see RQ14, RQ15
  wire [IO_CELLS-1:0] drive_out = mode_s2_reg.extest ? upd_s2_reg.out : core_drive.out;
  wire [IO_CELLS-1:0] drive_oe  = mode_s2_reg.extest ? upd_s2_reg.oe  : core_drive.oe;  // see RQ2

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_o          <= '0;
      io_oe         <= '0;
      aux_o         <= '0;
      aux_oe        <= '0;
      tms_pullup_en <= 1'b0;
      tdi_pullup_en <= 1'b0;
      dev_locked    <= 1'b0;
    end else begin
      io_o          <= drive_out;
      io_oe         <= pins_float ? '0 : drive_oe;
      aux_o         <= core_aux_o;
      aux_oe        <= jtag_en_reg ? '0 : core_aux_oe;        // see RQ10
      tms_pullup_en <= jtag_en_reg & pull_reg[1];             // see RQ12
      tdi_pullup_en <= jtag_en_reg & pull_reg[0];
      dev_locked    <= mode_s2_reg.lock;
    end
  end

  // two-entry buffer; the toggle is acknowledged only when a slot is free
  wire new_req  = (req_s2_reg != req_seen_reg);
  wire buf_push = new_req & ~tail_v_reg;
  wire buf_pop  = prog_valid & prog_ready;

  always_comb begin
    head_v_next = prog_valid;
    head_d_next = prog_data;
    tail_v_next = tail_v_reg;
    tail_d_next = tail_d_reg;
    if (buf_pop) begin
      head_v_next = tail_v_reg;
      head_d_next = tail_d_reg;
      tail_v_next = 1'b0;
    end
    if (buf_push) begin
      if (!head_v_next) begin
        head_v_next = 1'b1;
        head_d_next = prog_word_reg;
      end else begin
        tail_v_next = 1'b1;
        tail_d_next = prog_word_reg;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_valid   <= 1'b0;
      prog_data    <= '0;
      tail_v_reg   <= 1'b0;
      tail_d_reg   <= '0;
      req_seen_reg <= 1'b0;
    end else begin
      prog_valid   <= head_v_next;  // see RQ11
      prog_data    <= head_d_next;
      tail_v_reg   <= tail_v_next;
      tail_d_reg   <= tail_d_next;
      req_seen_reg <= buf_push ? req_s2_reg : req_seen_reg;
    end
  end

endmodule : boundary_scan_tap

//--- boundary_scan_tap_chk.sv
// concurrent checks on the pins of the boundary-scan test access port
`timescale 1ns/100ps
module boundary_scan_tap_chk
  import tap_pkg::*;
(
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rst_n,
  // link and straps
  input wire logic                tck,
  input wire logic                tdo_o,
  input wire logic                tdo_oe,
  input wire logic                jtag_en,
  input wire logic                cfg_tms_pullup,
  input wire logic                cfg_tdi_pullup,
  input wire logic                tms_pullup_en,
  input wire logic                tdi_pullup_en,
  // general I/O
  input wire logic [AUX_W-1:0]    aux_i,
  input wire logic [AUX_W-1:0]    aux_oe,
  input wire logic [AUX_W-1:0]    aux_in,
  // pins and programming stream
  input wire logic [IO_CELLS-1:0] io_oe,
  input wire logic                dev_locked,
  input wire logic                prog_valid,
  input wire logic                prog_ready,
  input wire logic [WORD_W-1:0]   prog_data
);
  // ----------------------------------------------------------------
  // helper: strap held steady for five samples
  // ----------------------------------------------------------------
  logic [3:0] en_h;
  logic       en_steady;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      en_h <= '0;
    else
      en_h <= {en_h[2:0], jtag_en};
  assign en_steady = (&{en_h, jtag_en}) || !(|{en_h, jtag_en});

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_pullup_tms: assert property (en_steady |-> tms_pullup_en == (cfg_tms_pullup && jtag_en))
    else $error("tms pull-up enable wrong");
  chk_pullup_tdi: assert property (en_steady |-> tdi_pullup_en == (cfg_tdi_pullup && jtag_en))
    else $error("tdi pull-up enable wrong");
  chk_aux_sync: assert property ($past(rst_n, 2) |-> aux_in == $past(aux_i, 2))
    else $error("gpio input not two cycles behind pin");
  chk_aux_blocked: assert property (en_steady && jtag_en |-> aux_oe == '0)
    else $error("gpio driven while test port active");
  chk_tdo_hold: assert property (tck && $past(tck) |-> $stable(tdo_o) && $stable(tdo_oe))
    else $error("tdo changed while tck high");
  chk_tdo_launch: assert property ($rose(tdo_oe) |-> !tck)
    else $error("tdo enabled outside a tck low phase");
  chk_lock_float: assert property (dev_locked && $past(dev_locked, 4) |-> io_oe == '0)
    else $error("pins driven while locked");
  chk_prog_hold: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data))
    else $error("programming word dropped while stalled");
endmodule : boundary_scan_tap_chk

bind boundary_scan_tap boundary_scan_tap_chk u_boundary_scan_tap_chk (
  .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .jtag_en(jtag_en),
  .cfg_tms_pullup(cfg_tms_pullup), .cfg_tdi_pullup(cfg_tdi_pullup), .tms_pullup_en(tms_pullup_en),
  .tdi_pullup_en(tdi_pullup_en), .aux_i(aux_i), .aux_oe(aux_oe), .aux_in(aux_in), .io_oe(io_oe),
  .dev_locked(dev_locked), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_data(prog_data)
);

//--- jtag_tester.sv
// behavioural test-link master; tck runs only while a sequence is walked
`timescale 1ns/100ps
module jtag_tester
  import tap_pkg::*;
(
  // link
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end

  // one period: levels set in the low phase, tdo taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5 tck = 1'h1;
    o = tdo;
    #62.5 tck = 1'h0;
  endtask : step

  // tdi toggles outside data bits so stale levels never look valid
  task automatic nav(input logic m);
    logic o;
    step(m, ~tdi, o);
  endtask : nav

  task automatic to_reset();
    repeat (5) nav(1'h1);
    nav(1'h0);
  endtask : to_reset

  // from run-test/idle: capture, shift n bits lsb first, update, idle
  task automatic scan(input logic ir, input int n, input logic [CHAIN_LEN-1:0] din,
                      output logic [CHAIN_LEN-1:0] dout);
    logic o;
    dout = '0;
    nav(1'h1);
    if (ir)
      nav(1'h1);
    nav(1'h0);
    nav(1'h0);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], o);
      dout[k] = o;
    end
    nav(1'h1);
    nav(1'h0);
    nav(1'h0);
  endtask : scan
endmodule : jtag_tester

//--- boundary_scan_tap_tb.sv
// self-checking bench for the boundary-scan test access port
`timescale 1ns/100ps
module boundary_scan_tap_tb
  import tap_pkg::*;
;
  localparam logic [WORD_W-1:0] ID = 32'h0C31_7A55;  // arbitrary value
  logic                 core_clk = 1'h0, rst_n = 1'h0, drain = 1'h0, prog_ready = 1'h0;
  logic                 jtag_en = 1'h1, cfg_tms_pullup = 1'h1, cfg_tdi_pullup = 1'h0, secure_fuse = 1'h0;
  logic                 tck, tms, tdi, tdo_o, tdo_oe, prog_valid, dev_locked, tms_pullup_en, tdi_pullup_en;
  logic [AUX_W-1:0]     aux_i = 4'h5, core_aux_o = 4'hA, core_aux_oe = 4'hF, aux_o, aux_oe, aux_in;
  pin_in_t              pin_i = '0;
  pin_drive_t           core_drive = '0;
  logic [MC_CELLS-1:0]  mc_state = '0;
  logic [IO_CELLS-1:0]  io_o, io_oe, exp_o, exp_e;
  logic [WORD_W-1:0]    cfg_readback = '0, prog_data, exp_q[$], got[$];
  logic [SIG_W-1:0]     user_signature = '0;
  logic [CHAIN_LEN-1:0] din, dout, exp_c;
  logic [IR_W-1:0]      codes [4] = '{IR_BYPASS, 4'h5, IR_HIGHZ, IR_IDCODE};
  int                   mismatches = 0, compares = 0;
  wire logic            tdo_w = tdo_oe ? tdo_o : ~tdo_o;

  initial forever #10 core_clk = ~core_clk;

  boundary_scan_tap #(.IDCODE_VALUE(ID)) u_boundary_scan_tap (
    .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .jtag_en(jtag_en), .cfg_tms_pullup(cfg_tms_pullup), .cfg_tdi_pullup(cfg_tdi_pullup),
    .tms_pullup_en(tms_pullup_en), .tdi_pullup_en(tdi_pullup_en), .aux_i(aux_i), .core_aux_o(core_aux_o),
    .core_aux_oe(core_aux_oe), .aux_o(aux_o), .aux_oe(aux_oe), .aux_in(aux_in), .pin_i(pin_i),
    .core_drive(core_drive), .mc_state(mc_state), .io_o(io_o), .io_oe(io_oe), .cfg_readback(cfg_readback),
    .user_signature(user_signature), .secure_fuse(secure_fuse), .prog_ready(prog_ready),
    .prog_data(prog_data), .prog_valid(prog_valid), .dev_locked(dev_locked));
  jtag_tester u_jtag_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [CHAIN_LEN-1:0] seen, input logic [CHAIN_LEN-1:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic rnd();
    for (int k = 0; k < CHAIN_LEN; k++)
      din[k] = 1'($urandom);
  endtask : rnd

  task automatic ir(input logic [IR_W-1:0] code);
    logic [CHAIN_LEN-1:0] d;
    u_jtag_tester.scan(1'h1, IR_W, CHAIN_LEN'(code), d);
    check("ir capture", d[IR_W-1:0], IR_CAPTURE);
    tick(8);
  endtask : ir

  // sink of the programming stream, stalling at random while draining
  always @(posedge core_clk) begin
    if (prog_valid && prog_ready)
      got.push_back(prog_data);
    prog_ready <= #1 drain & 1'($urandom);
  end

  initial begin
    #1_000_000;
    mismatches++;
    conclude();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(48));
    tick(2);
    rst_n = 1'h1;
    u_jtag_tester.to_reset();
    tick(1);
    check("pull-ups on", {tms_pullup_en, tdi_pullup_en}, 2'h2);
    check("gpio oe held off", aux_oe, 4'h0);
    pin_i = {$urandom, 4'($urandom)};
    core_drive = {$urandom, $urandom};
    mc_state = $urandom;
    u_jtag_tester.scan(1'h0, WORD_W, '0, dout);
    check("idcode after reset", dout[WORD_W-1:0], ID);
    $display("test reset_id done");
    foreach (codes[i]) begin
      ir(codes[i]);
      rnd();
      u_jtag_tester.scan(1'h0, 40, din, dout);
      if (codes[i] == IR_IDCODE)
        check("idcode", dout[WORD_W-1:0], ID);
      else
        check("bypass path", dout[39:0], {din[38:0], 1'h0});
      check("highz float", io_oe, (codes[i] == IR_HIGHZ) ? '0 : core_drive.oe);
    end
    $display("test instructions done");
    ir(IR_SAMPLE);
    rnd();
    for (int i = 0; i < IO_CELLS; i++) begin
      exp_c[3*i +: 3] = {core_drive.oe[i], core_drive.out[i], pin_i.io[i]};
      exp_o[i] = din[3*i+1];
      exp_e[i] = din[3*i+2];
    end
    exp_c[CHAIN_LEN-1:IN_BASE] = {mc_state, pin_i.in};
    u_jtag_tester.scan(1'h0, CHAIN_LEN, din, dout);
    check("sample chain", dout, exp_c);
    ir(IR_EXTEST);
    check("extest out", io_o, exp_o);
    check("extest oe", io_oe, exp_e);
    $display("test boundary done");
    for (int f = 0; f < 2; f++) begin
      secure_fuse = f[0];
      cfg_readback = $urandom;
      user_signature = 16'($urandom);
      ir(IR_VERIFY);
      u_jtag_tester.scan(1'h0, WORD_W, '0, dout);
      check("verify readback", dout[WORD_W-1:0], f ? 32'h0 : cfg_readback);
      ir(IR_SIG);
      u_jtag_tester.scan(1'h0, WORD_W, '0, dout);
      check("signature", dout[WORD_W-1:0], {16'h0, user_signature});
      tick(1);
    end
    $display("test security done");
    ir(IR_PROG);
    for (int w = 0; w < 4; w++) begin
      rnd();
      din[CHAIN_LEN-1:WORD_W] = '0;
      u_jtag_tester.scan(1'h0, WORD_W, din, dout);
      if (w < 3)
        exp_q.push_back(din[WORD_W-1:0]);
      check("busy flag", dout[0], w == 3);
      repeat (4) u_jtag_tester.nav(1'h0);
    end
    tick(4);
    check("stalled word", {prog_valid, prog_data}, {1'h1, exp_q[0]});
    drain = 1'h1;
    for (int t = 0; t < 200 && got.size() < 3; t++)
      tick(1);
    tick(20);
    check("word count", got.size(), 3);
    foreach (exp_q[i])
      check("programmed word", got[i], exp_q[i]);
    check("buffer empty", prog_valid, 1'h0);
    $display("test programming done");
    u_jtag_tester.to_reset();
    tick(10);
    check("lock", dev_locked, 1'h1);
    check("lock float", io_oe, '0);
    rst_n = 1'h0;
    {cfg_tms_pullup, cfg_tdi_pullup} = 2'h1;
    tick(2);
    rst_n = 1'h1;
    tick(4);
    check("lock cleared", dev_locked, 1'h0);
    check("pull-ups swapped", {tms_pullup_en, tdi_pullup_en}, 2'h1);
    $display("test lock done");
    jtag_en = 1'h0;
    aux_i = 4'($urandom);
    core_aux_o = 4'($urandom);
    core_aux_oe = 4'($urandom);
    tick(6);
    check("gpio out", {aux_o, aux_oe}, {core_aux_o, core_aux_oe});
    check("gpio in", aux_in, aux_i);
    check("pull-ups off", {tms_pullup_en, tdi_pullup_en}, 2'h0);
    $display("test gpio done");
    conclude();
  end
endmodule : boundary_scan_tap_tb
